/* verilog/lss_defs.vh */
`ifndef LSS_DEFS_VH
`define LSS_DEFS_VH

`define LSS_ADDR_W           6
`define LSS_OFF_STATE        6'h24
`define LSS_OFF_TIMER        6'h28
`define LSS_OFF_CTRL         6'h2c
`define LSS_OFF_IRQ_STATUS   6'h30
`define LSS_OFF_IRQ_MASK     6'h34

`define LSS_BIT_BITRATE      0
`define LSS_BIT_PROTOCOL     1
`define LSS_BIT_MGMT         2
`define LSS_BIT_VSS          3
`define LSS_STATE_LSB        8
`define LSS_STATE_MSB        10
`define LSS_BIT_EXPIRED      16
`define LSS_TIMER_W          20

`define LSS_BIT_HDLC_AUTO    0
`define LSS_BIT_ETH_AUTO     1
`define LSS_BIT_PROT_AUTO    2
`define LSS_BIT_MGMT_FAIL    3

`define LSS_CODE_A           3'h0
`define LSS_CODE_B           3'h1
`define LSS_CODE_C           3'h3
`define LSS_CODE_D           3'h2
`define LSS_CODE_E           3'h6
`define LSS_CODE_F           3'h7
`define LSS_CODE_G           3'h5

`define LSS_IRQ_EXPIRED      0
`define LSS_IRQ_STATE        1
`define LSS_IRQ_PASSIVE      2
`define LSS_IRQ_W            3

`define LSS_RST_TIMER        20'h00000
`define LSS_RST_CTRL         4'h0

`endif

/* verilog/lss_timer.v */
`timescale 1ns/100ps
`include "lss_defs.vh"

module lss_timer #(
  parameter W = `LSS_TIMER_W
) (
  input  wire         ref_clk,   // Core clock
  input  wire         rst_n,     // Sync reset
  input  wire         restart,   // Clear count and flag
  input  wire [W-1:0] threshold, // Cycles to expiry
  output reg          expired    // Sticky until restart
);

  reg [W-1:0] count;

  always @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      count   <= {W{1'b0}};
      expired <= 1'b0;
    end else if (!expired) begin
      if (count >= threshold) begin
        expired <= 1'b1;
      end else begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // lss_timer

/* verilog/lss_regs.v */
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "lss_defs.vh"

module lss_regs #(
  parameter ENABLE_SM = 1,
  parameter TW        = `LSS_TIMER_W
) (
  input  wire        ref_clk,                  // Core clock, 40 MHz
  input  wire        rst_n,                    // Sync reset, active low
  input  wire [5:0]  avs_address,              // Byte address
  input  wire        avs_read,                 // Read request
  input  wire        avs_write,                // Write request
  input  wire [31:0] avs_writedata,            // Write data
  input  wire [3:0]  avs_byteenable,           // Byte lanes
  output reg  [31:0] avs_readdata,             // Read data
  output wire        avs_waitrequest,          // Stall
  output reg  [1:0]  avs_response,             // 00 ok, 10 slave error
  input  wire        bitrate_done_in,          // Bit rate negotiated
  input  wire        protocol_done_in,         // Protocol negotiated
  input  wire        mgmt_negotiation_done_in, // Management negotiated
  input  wire        vss_done_in,              // Vendor negotiated
  input  wire        link_sync_in,             // Layer-1 sync reached
  input  wire        link_lost_in,             // Layer-1 sync lost
  input  wire        mgmt_fail_in,             // Management negotiation failed
  output reg         irq,                      // Level interrupt
  output reg  [2:0]  startup_state             // Current state code
);

  localparam ST_A = 7'h01;
  localparam ST_B = 7'h02;
  localparam ST_C = 7'h04;
  localparam ST_D = 7'h08;
  localparam ST_E = 7'h10;
  localparam ST_F = 7'h20;
  localparam ST_G = 7'h40;

  function [2:0] state_code;
    input [6:0] s;
    begin
      case (s)
        ST_A:    state_code = `LSS_CODE_A;
        ST_B:    state_code = `LSS_CODE_B;
        ST_C:    state_code = `LSS_CODE_C;
        ST_D:    state_code = `LSS_CODE_D;
        ST_E:    state_code = `LSS_CODE_E;
        ST_F:    state_code = `LSS_CODE_F;
        ST_G:    state_code = `LSS_CODE_G;
        default: state_code = `LSS_CODE_A;
      endcase
    end
  endfunction

  // Pin inputs come from other logic domains
  reg [6:0] sync1;
  reg [6:0] sync2;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= {mgmt_fail_in, link_lost_in, link_sync_in, vss_done_in,
                mgmt_negotiation_done_in, protocol_done_in, bitrate_done_in};
      sync2 <= sync1;
    end
  end
  wire [3:0] nego_pin  = sync2[3:0];
  wire       l1_sync   = sync2[4];
  wire       l1_lost   = sync2[5];
  wire       mgmt_fail = sync2[6];

  reg [3:0] nego_pin_d;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      nego_pin_d <= 4'h0;
    end else begin
      nego_pin_d <= nego_pin;
    end
  end
  wire [3:0] nego_pin_chg = nego_pin ^ nego_pin_d;

  // Reads stall one cycle so registered data stands at the accepting edge
  reg rd_valid;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= avs_read && !rd_valid;
    end
  end
  assign avs_waitrequest = avs_read && !rd_valid;

  wire sel_state  = (avs_address == `LSS_OFF_STATE) && (ENABLE_SM != 0);
  wire sel_timer  = (avs_address == `LSS_OFF_TIMER) && (ENABLE_SM != 0);
  wire sel_ctrl   = (avs_address == `LSS_OFF_CTRL);
  wire sel_status = (avs_address == `LSS_OFF_IRQ_STATUS);
  wire sel_mask   = (avs_address == `LSS_OFF_IRQ_MASK);
  wire mapped     = sel_state | sel_timer | sel_ctrl | sel_status | sel_mask;

  wire wr_state = avs_write && sel_state && avs_byteenable[0];
  wire wr_ctrl  = avs_write && sel_ctrl && avs_byteenable[0];
  wire wr_mask  = avs_write && sel_mask && avs_byteenable[0];
  // Clear only in the capture cycle, or an event set meanwhile is lost
  wire rd_stat  = avs_read && sel_status && !rd_valid;

  reg [3:0]    nego;
  reg [TW-1:0] threshold;
  reg [3:0]    ctrl;
  reg [6:0]    state;
  reg [6:0]    next_state;
  reg [`LSS_IRQ_W-1:0] irq_status;
  reg [`LSS_IRQ_W-1:0] irq_mask;
  wire         expired;

  wire hdlc_auto   = ctrl[`LSS_BIT_HDLC_AUTO];
  wire eth_auto    = ctrl[`LSS_BIT_ETH_AUTO];
  wire prot_auto   = ctrl[`LSS_BIT_PROT_AUTO];
  wire fail_soft   = ctrl[`LSS_BIT_MGMT_FAIL];
  wire mgmt_failed = mgmt_fail | fail_soft;

  // Threshold register, byte-lane writes
  integer i;
  integer j;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      threshold <= `LSS_RST_TIMER;
    end else if (avs_write && sel_timer) begin
      for (i = 0; i < TW; i = i + 1) begin
        if (avs_byteenable[i/8]) begin
          threshold[i] <= avs_writedata[i];
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl     <= `LSS_RST_CTRL;
      irq_mask <= {`LSS_IRQ_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl <= avs_writedata[3:0];
      end
      if (wr_mask) begin
        irq_mask <= avs_writedata[`LSS_IRQ_W-1:0];
      end
    end
  end

  // Negotiation bits: pin edge or software write, auto-set on top
  always @(posedge ref_clk) begin
    if (!rst_n || ENABLE_SM == 0) begin
      nego <= 4'h0;
    end else begin
      if (wr_state) begin
        nego <= avs_writedata[3:0];
      end
      for (j = 0; j < 4; j = j + 1) begin
        if (nego_pin_chg[j]) begin
          nego[j] <= nego_pin[j];
        end
      end
      if (state == ST_C && prot_auto && !nego[`LSS_BIT_PROTOCOL]) begin
        nego[`LSS_BIT_PROTOCOL] <= 1'b1;
      end
      if (state == ST_D && (hdlc_auto || eth_auto) && !mgmt_failed
          && !nego[`LSS_BIT_MGMT]) begin
        nego[`LSS_BIT_MGMT] <= 1'b1;
      end
      if (state == ST_D && mgmt_failed) begin
        nego[`LSS_BIT_MGMT] <= 1'b0;
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_A: begin
        next_state = ST_B;
      end
      ST_B: begin
        if (l1_sync && nego[`LSS_BIT_BITRATE]) begin
          next_state = ST_C;
        end
      end
      ST_C: begin
        if (nego[`LSS_BIT_PROTOCOL]) begin
          next_state = ST_D;
        end
      end
      ST_D: begin
        if (mgmt_failed) begin
          next_state = ST_G;
        end else if (nego[`LSS_BIT_MGMT]) begin
          next_state = ST_E;
        end
      end
      ST_E: begin
        if (nego[`LSS_BIT_VSS]) begin
          next_state = ST_F;
        end
      end
      ST_F: begin
        next_state = ST_F;
      end
      ST_G: begin
        next_state = ST_G;
      end
      default: begin
        next_state = ST_A;
      end
    endcase
    if (l1_lost && state != ST_A) begin
      next_state = ST_B;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n || ENABLE_SM == 0) begin
      state <= ST_A;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n || ENABLE_SM == 0) begin
      startup_state <= `LSS_CODE_A;
    end else begin
      startup_state <= state_code(next_state);
    end
  end

  // Timer restarts on every state change so each state gets a full period
  wire timer_restart = (next_state != state) || (ENABLE_SM == 0);
  lss_timer #(
    .W(TW)
  ) u_timer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .restart   (timer_restart),
    .threshold (threshold),
    .expired   (expired)
  );

  reg expired_d;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      expired_d <= 1'b0;
    end else begin
      expired_d <= expired;
    end
  end

  wire [`LSS_IRQ_W-1:0] irq_event;
  assign irq_event[`LSS_IRQ_EXPIRED] = expired & ~expired_d;
  assign irq_event[`LSS_IRQ_STATE]   = next_state != state;
  assign irq_event[`LSS_IRQ_PASSIVE] = (next_state == ST_G) && (state != ST_G);

  // Set wins over read-clear
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= {`LSS_IRQ_W{1'b0}};
      irq       <= 1'b0;
    end else begin
      irq_status <= (rd_stat ? {`LSS_IRQ_W{1'b0}} : irq_status) | irq_event;
      irq <= |(((rd_stat ? {`LSS_IRQ_W{1'b0}} : irq_status) | irq_event) & irq_mask);
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else begin
      avs_readdata <= 32'h00000000;
      avs_response <= (avs_read || avs_write) && !mapped ? 2'h2 : 2'h0;
      if (avs_read && !rd_valid) begin
        if (sel_state) begin
          avs_readdata[`LSS_BIT_EXPIRED] <= expired;
          avs_readdata[`LSS_STATE_MSB:`LSS_STATE_LSB] <= state_code(state);
          avs_readdata[3:0] <= nego;
        end else if (sel_timer) begin
          avs_readdata[TW-1:0] <= threshold;
        end else if (sel_ctrl) begin
          avs_readdata[3:0] <= ctrl;
        end else if (sel_status) begin
          avs_readdata[`LSS_IRQ_W-1:0] <= irq_status;
        end else if (sel_mask) begin
          avs_readdata[`LSS_IRQ_W-1:0] <= irq_mask;
        end
      end
    end
  end

endmodule // lss_regs

/* sim/lss_peer.sv */
`timescale 1ns/100ps
module lss_peer (
  input  wire ref_clk,                  // Core clock
  output reg  bitrate_done_in,          // Bit rate agreed
  output reg  protocol_done_in,         // Protocol agreed
  output reg  mgmt_negotiation_done_in, // Management agreed
  output reg  vss_done_in,              // Vendor agreed
  output reg  link_sync_in,             // Layer-1 sync
  output reg  link_lost_in,             // Sync lost
  output reg  mgmt_fail_in              // Management refused
);
  initial begin
    {link_lost_in, mgmt_fail_in, link_sync_in} = 3'h0;
    {vss_done_in, mgmt_negotiation_done_in, protocol_done_in, bitrate_done_in} = 4'h0;
  end
  // Lag lets a scenario answer promptly or slowly; pins move after lag clock edges, at once when lag is 0
  task drive(input [6:0] v, input integer lag);
    begin
      repeat (lag) @(posedge ref_clk);
      {link_lost_in, mgmt_fail_in, link_sync_in} <= v[6:4];
      {vss_done_in, mgmt_negotiation_done_in, protocol_done_in, bitrate_done_in} <= v[3:0];
    end
  endtask
endmodule // lss_peer

/* sim/lss_regs_assertions.sv */
`timescale 1ns/100ps
module lss_regs_chk #(
  parameter ENABLE_SM = 1
) (
  input wire        ref_clk,         // Core clock
  input wire        rst_n,           // Sync reset
  input wire [5:0]  avs_address,     // Byte address
  input wire        avs_read,        // Read request
  input wire        avs_write,       // Write request
  input wire [31:0] avs_readdata,    // Read data
  input wire        avs_waitrequest, // Stall
  input wire [1:0]  avs_response,    // Response code
  input wire [2:0]  startup_state    // State code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire mapped = avs_address[1:0] == 2'h0 && avs_address <= 6'h34 &&
                avs_address >= (ENABLE_SM ? 6'h24 : 6'h2c);
  chk_write_no_stall: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_read_first_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
    else $error("read answered before data ready");
  chk_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read stalled too long");
  chk_code_legal: assert property (startup_state != 3'h4) else $error("bad state");
  chk_f_entry: assert property (startup_state == 3'h7 && $changed(startup_state)
    |-> $past(startup_state) == 3'h6) else $error("F not from E");
  chk_e_entry: assert property (startup_state == 3'h6 && $changed(startup_state)
    |-> $past(startup_state) == 3'h2) else $error("E not from D");
  chk_g_entry: assert property (startup_state == 3'h5 && $changed(startup_state)
    |-> $past(startup_state) == 3'h2) else $error("G not from D");
  chk_d_entry: assert property (startup_state == 3'h2 && $changed(startup_state)
    |-> $past(startup_state) == 3'h3) else $error("D not from C");
  chk_map_ok: assert property (avs_read && mapped |=> avs_response == 2'h0)
    else $error("mapped read refused");
  chk_unmapped_err: assert property (avs_read && !mapped |=> avs_response == 2'h2)
    else $error("unmapped read accepted");
  chk_state_rsvd: assert property (avs_read && avs_address == 6'h24
    |=> (avs_readdata & 32'hfffef8f0) == 32'h0) else $error("state reserved set");
  chk_timer_rsvd: assert property (avs_read && avs_address == 6'h28
    |=> avs_readdata[31:20] == 12'h0) else $error("timer reserved set");
  chk_data_drop: assert property (!avs_read |=> avs_readdata == 32'h0)
    else $error("stale read data");
endmodule // lss_regs_chk
bind lss_regs lss_regs_chk #(.ENABLE_SM(ENABLE_SM)) i_lss_regs_chk (.ref_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
  .startup_state);

/* sim/tb.sv */
`timescale 1ns/100ps
module tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [5:0]  avs_address = 6'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hf;
  reg  [31:0] rd;
  reg  [1:0]  rs;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response;
  wire [2:0]  startup_state;
  wire        avs_waitrequest, irq, link_sync_in, link_lost_in, mgmt_fail_in;
  wire        bitrate_done_in, protocol_done_in, mgmt_negotiation_done_in, vss_done_in;
  integer     n_fail = 0;
  integer     check_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  lss_regs i_lss_regs (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .bitrate_done_in, .protocol_done_in, .mgmt_negotiation_done_in, .vss_done_in,
    .link_sync_in, .link_lost_in, .mgmt_fail_in, .irq, .startup_state);
  lss_peer i_lss_peer (.ref_clk, .bitrate_done_in, .protocol_done_in,
    .mgmt_negotiation_done_in, .vss_done_in, .link_sync_in, .link_lost_in, .mgmt_fail_in);
  task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s: expected %h seen %h", what, want, seen);
      end
    end
  endtask
  // Edge before the request keeps back-to-back calls from reassigning a strobe
  task xfer(input wr, input [5:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge ref_clk);
      end
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rd_chk(input [5:0] a, input [31:0] m, input [31:0] want, input [8*8-1:0] n);
    begin
      xfer(1'b0, a, 32'h0);
      check(n, rd & m, want);
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(4);
    rd_chk(6'h24, 32'hffffffff, 32'h00010100, "state");
    rd_chk(6'h28, 32'hffffffff, 32'h0, "thresh");
    xfer(1'b1, 6'h28, 32'hffffffff);
    rd_chk(6'h28, 32'hffffffff, 32'h000fffff, "thresh");
    xfer(1'b0, 6'h3c, 32'h0);
    check("resp", rs, 2'h2);
    $display("test registers done");
    i_lss_peer.drive(7'h11, 1);
    idle(10);
    rd_chk(6'h24, 32'hffffffff, 32'h00000301, "state");
    i_lss_peer.drive(7'h13, 1);
    idle(10);
    rd_chk(6'h24, 32'hffffffff, 32'h00000203, "state");
    xfer(1'b1, 6'h24, 32'h7);
    idle(10);
    rd_chk(6'h24, 32'hffffffff, 32'h00000607, "state");
    rd_chk(6'h30, 32'hffffffff, 32'h3, "status");
    xfer(1'b1, 6'h34, 32'h1);
    idle(2);
    check("irq", irq, 1'b0);
    i_lss_peer.drive(7'h1b, 1);
    idle(10);
    rd_chk(6'h24, 32'hffffffff, 32'h0000070f, "state");
    $display("test handshake done");
    xfer(1'b1, 6'h28, 32'h5);
    idle(12);
    check("irq", irq, 1'b1);
    rd_chk(6'h24, 32'hffffffff, 32'h0001070f, "state");
    rd_chk(6'h30, 32'h1, 32'h1, "status");
    idle(2);
    check("irq", irq, 1'b0);
    $display("test timer done");
    xfer(1'b1, 6'h2c, 32'h5);
    xfer(1'b1, 6'h24, 32'h1);
    i_lss_peer.drive(7'h51, 1);
    i_lss_peer.drive(7'h11, 4);
    idle(30);
    rd_chk(6'h24, 32'h0000070f, 32'h00000607, "state");
    $display("test auto done");
    xfer(1'b1, 6'h2c, 32'h6);
    xfer(1'b1, 6'h24, 32'h1);
    i_lss_peer.drive(7'h71, 1);
    i_lss_peer.drive(7'h31, 4);
    idle(30);
    rd_chk(6'h24, 32'h0000070f, 32'h00000503, "state");
    rd_chk(6'h30, 32'h4, 32'h4, "status");
    $display("test passive done");
    report_and_stop;
  end
endmodule // tb
